/* File: uart_so_defs.svh */
// Register indices, field positions and command codes for the status and
// output-select block.
// Assumes a word-indexed bus: byte address is four times the index.
// Notes on behaviour
// - Transmitter ready reads 1 while the transmitter is enabled and the transmit FIFO has a free place.
// - A CPU write that fills the transmit FIFO clears transmitter ready.
// - Moving a character to the transmit shifter sets transmitter ready.
// - Disabling the transmitter clears ready; enabling it sets ready unless the transmit FIFO is still full.
// - A character written while transmitter ready is 0 is discarded.
// - Receive full sets when a push fills all 8 (or 16) places.
// - A data read clears receive full unless a character waits to enter.
// - Receiver ready sets on a push and clears only when a read empties it or on receiver reset.
// - Break, framing and parity bits travel with each received character.
// - In character mode error bits leave with the character or on reset.
// - In block mode errors accumulate until error or receiver reset.
// - Channel B status has channel A's layout for channel B's logic.
// - Pin 7 follows the select register, pins 6..2 the port value; pins 1..0 follow core logic.
// - By default each of pins 7..2 drives the inverse of its output port bit.
// - The interrupt source on pin 7 drives low only, else the pin drives both levels.
// - Select bit 7 puts inverted channel B transmit ready on pin 7.
`ifndef UART_SO_DEFS_SVH
`define UART_SO_DEFS_SVH
`define IDX_CFG 4'h0
`define IDX_STAT_A 4'h1
`define IDX_CMD_A 4'h2
`define IDX_DATA_A 4'h3
`define IDX_EVT 4'h5
`define IDX_MASK 4'h6
`define IDX_STAT_B 4'h9
`define IDX_CMD_B 4'ha
`define IDX_DATA_B 4'hb
`define IDX_OPV 4'hc
`define IDX_OPSEL 4'hd
`define CMD_RST_RX 4'h2
`define CMD_RST_TX 4'h3
`define CMD_RST_ERR 4'h4
`define CMD_TX_EN_BIT 2
`define CMD_TX_DIS_BIT 3
`define CFG_DEEP_BIT 0
`define CFG_BLOCK_BIT 1
`define DEPTH_SHALLOW 5'h08
`define DEPTH_DEEP 5'h10
`define SEL_OP7_BIT 7
`endif

/* File: uart_so_pkg.sv */
// Types for the status and output-select block.
// Assumes the FIFOs hold at most sixteen entries.
package uart_so_pkg;
  typedef struct packed {
    logic [15:0][7:0] tq;
    logic [3:0] trd;
    logic [3:0] twr;
    logic [4:0] tcnt;
    logic ten;
    logic txrdy;
    logic tvalid;
    logic [7:0] tdata;
    logic [15:0][10:0] rq;
    logic [3:0] rrd;
    logic [3:0] rwr;
    logic [4:0] rcnt;
    logic hv;
    logic [10:0] hold;
    logic ovr;
    logic [2:0] acc;
    logic rxrdy;
    logic rxfull;
  } chan_t;
  typedef struct packed {
    chan_t [1:0] ch;
    logic [7:0] cfg;
    logic [7:0] opsel;
    logic [7:0] opv;
    logic [3:0] evt;
    logic [3:0] mask;
    logic waitrequest;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] pout;
    logic [7:0] poe;
  } state_t;
endpackage : uart_so_pkg

/* File: uart_status_outsel.sv */
// Dual-channel status flags, FIFO bookkeeping and output pin selection.
// Assumes receiver, transmitter and pin-0/1 logic share sys_clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "uart_so_defs.svh"
module uart_status_outsel (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Receiver side, index 0 is channel A.
  input wire logic [1:0] rx_valid_in,
  input wire logic [1:0][7:0] rx_char_in,
  input wire logic [1:0][2:0] rx_err_in,
  // Transmitter side.
  input wire logic [1:0] tx_take_in,
  input wire logic [1:0] tx_idle_in,
  output logic [1:0] tx_valid_out,
  output logic [1:0][7:0] tx_data_out,
  // Output port pins.
  input wire logic [1:0] op_low_in,
  output logic [7:0] op_out,
  output logic [7:0] op_oe_out,
  // Interrupt.
  output logic irq_out
);
  import uart_so_pkg::*;

  state_t s;
  state_t n;
  logic go;
  logic wr;
  logic rd;
  logic [4:0] depth;
  logic [3:0] cmd;
  logic [3:0] cidx;
  logic [3:0] didx;
  logic wcmd;
  logic [10:0] ent;

  // Status byte; the upper three bits come from the oldest entry, or from the accumulated errors in block mode.
  function automatic logic [7:0] stat(input chan_t c, input logic blk,
                                      input logic idle);
    logic [2:0] err;
    err = blk ? c.acc : (c.rcnt != 5'h00 ? c.rq[c.rrd][10:8] : 3'h0);
    return {err, c.ovr, c.ten && c.tcnt == 5'h00 && idle, c.txrdy,
            c.rxfull, c.rxrdy};
  endfunction : stat

  always_comb begin
    n = s;
    cmd = avs_writedata_in[7:4];
    cidx = `IDX_CMD_A;
    didx = `IDX_DATA_A;
    wcmd = 1'b0;
    ent = 11'h000;
    depth = s.cfg[`CFG_DEEP_BIT] ? `DEPTH_DEEP : `DEPTH_SHALLOW;
    go = (avs_read_in || avs_write_in) && s.waitrequest;
    wr = go && avs_write_in;
    rd = go && avs_read_in;
    // One wait state: the access acts at the edge that drops
    // waitrequest, and a request still held two edges later acts again.
    n.waitrequest = !go;
    if (rd) begin
      unique case (avs_address_in)
        `IDX_CFG: n.rdata = s.cfg;
        `IDX_STAT_A: n.rdata = stat(s.ch[0], s.cfg[`CFG_BLOCK_BIT],
                                    tx_idle_in[0]);
        `IDX_STAT_B: n.rdata = stat(s.ch[1], s.cfg[`CFG_BLOCK_BIT + 1],
                                    tx_idle_in[1]);
        `IDX_DATA_A: n.rdata = s.ch[0].rq[s.ch[0].rrd][7:0];
        `IDX_DATA_B: n.rdata = s.ch[1].rq[s.ch[1].rrd][7:0];
        `IDX_EVT: n.rdata = {4'h0, s.evt};
        `IDX_MASK: n.rdata = {4'h0, s.mask};
        `IDX_OPV: n.rdata = s.opv;
        `IDX_OPSEL: n.rdata = s.opsel;
        default: n.rdata = 8'h00;
      endcase
      if (avs_address_in == `IDX_EVT) begin
        n.evt = 4'h0;
      end
    end
    if (wr) begin
      unique case (avs_address_in)
        `IDX_CFG: n.cfg = avs_writedata_in[7:0];
        `IDX_MASK: n.mask = avs_writedata_in[3:0];
        `IDX_OPV: n.opv = avs_writedata_in[7:0];
        `IDX_OPSEL: n.opsel = avs_writedata_in[7:0];
        default: n.cfg = s.cfg;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      cidx = (i == 0) ? `IDX_CMD_A : `IDX_CMD_B;
      didx = (i == 0) ? `IDX_DATA_A : `IDX_DATA_B;
      wcmd = wr && avs_address_in == cidx;
      // Transmit side.
      if (wcmd && avs_writedata_in[`CMD_TX_EN_BIT]) begin
        n.ch[i].ten = 1'b1;
      end
      if (wcmd && avs_writedata_in[`CMD_TX_DIS_BIT]) begin
        n.ch[i].ten = 1'b0;
      end
      if (tx_take_in[i] && s.ch[i].tvalid) begin
        n.ch[i].trd = s.ch[i].trd + 4'h1;
        n.ch[i].tcnt = n.ch[i].tcnt - 5'h01;
      end
      // A write while not ready is dropped without a trace.
      if (wr && avs_address_in == didx && s.ch[i].txrdy) begin
        n.ch[i].tq[s.ch[i].twr] = avs_writedata_in[7:0];
        n.ch[i].twr = s.ch[i].twr + 4'h1;
        n.ch[i].tcnt = n.ch[i].tcnt + 5'h01;
      end
      if (wcmd && cmd == `CMD_RST_TX) begin
        n.ch[i].ten = 1'b0;
        n.ch[i].tcnt = 5'h00;
        n.ch[i].trd = n.ch[i].twr;
      end
      n.ch[i].txrdy = n.ch[i].ten && n.ch[i].tcnt < depth;
      n.ch[i].tvalid = n.ch[i].ten && n.ch[i].tcnt != 5'h00;
      n.ch[i].tdata = n.ch[i].tq[n.ch[i].trd];
      // Receive side: pop first, then the waiting character, then new.
      if (rd && avs_address_in == didx && s.ch[i].rcnt != 5'h00) begin
        n.ch[i].rrd = s.ch[i].rrd + 4'h1;
        n.ch[i].rcnt = s.ch[i].rcnt - 5'h01;
      end
      if (s.ch[i].hv && n.ch[i].rcnt < depth) begin
        n.ch[i].rq[n.ch[i].rwr] = s.ch[i].hold;
        n.ch[i].rwr = n.ch[i].rwr + 4'h1;
        n.ch[i].rcnt = n.ch[i].rcnt + 5'h01;
        n.ch[i].hv = 1'b0;
      end
      // Clearing ahead of the arrivals lets a coincident error survive.
      if (wcmd && cmd == `CMD_RST_ERR) begin
        for (int j = 0; j < 16; j++) begin
          n.ch[i].rq[j][10:8] = 3'h0;
        end
        n.ch[i].hold[10:8] = 3'h0;
        n.ch[i].acc = 3'h0;
        n.ch[i].ovr = 1'b0;
      end
      if (rx_valid_in[i]) begin
        ent = {rx_err_in[i], rx_char_in[i]};
        if (s.cfg[`CFG_BLOCK_BIT + i]) begin
          n.ch[i].acc = n.ch[i].acc | rx_err_in[i];
        end
        if (!n.ch[i].hv && n.ch[i].rcnt < depth) begin
          n.ch[i].rq[n.ch[i].rwr] = ent;
          n.ch[i].rwr = n.ch[i].rwr + 4'h1;
          n.ch[i].rcnt = n.ch[i].rcnt + 5'h01;
        end else if (!n.ch[i].hv) begin
          n.ch[i].hold = ent;
          n.ch[i].hv = 1'b1;
        end else begin
          // The newcomer is lost; its error bits reach only the block-mode accumulator.
          n.ch[i].ovr = 1'b1;
        end
      end
      if (wcmd && cmd == `CMD_RST_RX) begin
        n.ch[i].rcnt = 5'h00;
        n.ch[i].rrd = n.ch[i].rwr;
        n.ch[i].hv = 1'b0;
        n.ch[i].acc = 3'h0;
        n.ch[i].ovr = 1'b0;
      end
      n.ch[i].rxrdy = n.ch[i].rcnt != 5'h00;
      n.ch[i].rxfull = n.ch[i].rcnt >= depth;
      // Events set after the read clear, so a coincident event survives.
      if (n.ch[i].rxrdy && !s.ch[i].rxrdy) begin
        n.evt[2 * i] = 1'b1;
      end
      if (n.ch[i].txrdy && !s.ch[i].txrdy) begin
        n.evt[2 * i + 1] = 1'b1;
      end
    end
    n.irq = |(n.evt & n.mask);
    n.pout[1:0] = op_low_in;
    n.poe[1:0] = 2'h3;
    n.pout[6:2] = ~n.opv[6:2];
    n.poe[6:2] = 5'h1f;
    if (n.opsel[`SEL_OP7_BIT]) begin
      // Open drain: pulled low while channel B can take a character.
      n.pout[7] = 1'b0;
      n.poe[7] = n.ch[1].txrdy;
    end else begin
      n.pout[7] = ~n.opv[7];
      n.poe[7] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
      s.waitrequest <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_out = {24'h000000, s.rdata};
  assign avs_waitrequest_out = s.waitrequest;
  assign tx_valid_out = {s.ch[1].tvalid, s.ch[0].tvalid};
  assign tx_data_out = {s.ch[1].tdata, s.ch[0].tdata};
  assign op_out = s.pout;
  assign op_oe_out = s.poe;
  assign irq_out = s.irq;

  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence q_wr_a_last;
    avs_write_in && s.waitrequest && avs_address_in == `IDX_DATA_A &&
      s.ch[0].txrdy && s.ch[0].tcnt == 5'h07 && !s.cfg[`CFG_DEEP_BIT] &&
      !tx_take_in[0];
  endsequence
  property p_tx_fill;
    q_wr_a_last |=> !s.ch[0].txrdy && s.ch[0].tcnt == 5'h08;
  endproperty
  a_tx_fill: assert property (p_tx_fill)
    else $error("tx ready stayed high after fill");

  property p_tx_drop;
    avs_write_in && s.waitrequest && avs_address_in == `IDX_DATA_A &&
      !s.ch[0].txrdy && !tx_take_in[0] |=> $stable(s.ch[0].tcnt);
  endproperty
  a_tx_drop: assert property (p_tx_drop)
    else $error("write accepted while not ready");

  property p_tx_take;
    tx_take_in[0] && s.ch[0].tvalid && s.ch[0].ten && !avs_write_in
      |=> s.ch[0].txrdy;
  endproperty
  a_tx_take: assert property (p_tx_take)
    else $error("ready not set after transfer");

  property p_tx_dis;
    avs_write_in && s.waitrequest && avs_address_in == `IDX_CMD_A &&
      avs_writedata_in[`CMD_TX_DIS_BIT] |=> !s.ch[0].txrdy ##1
      !tx_valid_out[0];
  endproperty
  a_tx_dis: assert property (p_tx_dis)
    else $error("disable did not clear ready");

  sequence q_rx_in;
    rx_valid_in[0] && !s.ch[0].hv && s.ch[0].rcnt == 5'h07 &&
      !s.cfg[`CFG_DEEP_BIT] && !avs_write_in && !avs_read_in;
  endsequence
  property p_rx_full;
    q_rx_in |=> s.ch[0].rxfull && s.ch[0].rxrdy;
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("full flag not set on last place");

  property p_stat_read;
    avs_read_in && s.waitrequest && avs_address_in == `IDX_STAT_A &&
      !rx_valid_in[0] && !tx_take_in[0] |=> $stable(s.ch[0].rcnt) &&
      $stable(s.ch[0].rxfull) && !avs_waitrequest_out;
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read changed state");

  property p_op7_irq;
    s.opsel[`SEL_OP7_BIT] && s.ch[1].txrdy |-> op_oe_out[7] && !op_out[7];
  endproperty
  a_op7_irq: assert property (p_op7_irq)
    else $error("pin seven not pulled low");

  property p_op_default;
    op_oe_out[2] && !s.opsel[`SEL_OP7_BIT] |-> op_oe_out[7] &&
      op_out[7] == ~s.opv[7];
  endproperty
  a_op_default: assert property (p_op_default)
    else $error("pin seven not inverse of port bit");

  property p_bus_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=>
      !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("no answer after one wait state");

  // Receive-side checks for channel A admit no channel A command but the error reset, so that no
  // command can reset the FIFO underneath them.
  sequence q_rx_first;
    rx_valid_in[0] && !s.ch[0].hv && s.ch[0].rcnt == 5'h00 &&
      !avs_write_in;
  endsequence
  property p_rx_ready_set;
    q_rx_first |=> s.ch[0].rxrdy;
  endproperty
  a_rx_ready_set: assert property (p_rx_ready_set)
    else $error("rx ready not set on first character");

  sequence q_rd_a_more;
    avs_read_in && s.waitrequest && avs_address_in == `IDX_DATA_A &&
      s.ch[0].rcnt > 5'h01;
  endsequence
  property p_rx_ready_keep;
    q_rd_a_more |=> s.ch[0].rxrdy;
  endproperty
  a_rx_ready_keep: assert property (p_rx_ready_keep)
    else $error("rx ready cleared with characters left");

  sequence q_rd_a_last;
    avs_read_in && s.waitrequest && avs_address_in == `IDX_DATA_A &&
      s.ch[0].rcnt == 5'h01 && !s.ch[0].hv && !rx_valid_in[0];
  endsequence
  property p_rx_ready_clr;
    q_rd_a_last |=> !s.ch[0].rxrdy;
  endproperty
  a_rx_ready_clr: assert property (p_rx_ready_clr)
    else $error("rx ready stayed set on empty fifo");

  sequence q_rd_a_full;
    avs_read_in && s.waitrequest && avs_address_in == `IDX_DATA_A &&
      s.ch[0].rxfull;
  endsequence
  property p_full_held;
    q_rd_a_full ##0 s.ch[0].hv |=> s.ch[0].rxfull;
  endproperty
  a_full_held: assert property (p_full_held)
    else $error("full cleared while a character waits");

  property p_full_clr;
    q_rd_a_full ##0 !s.ch[0].hv && !rx_valid_in[0] |=> !s.ch[0].rxfull;
  endproperty
  a_full_clr: assert property (p_full_clr)
    else $error("full not cleared by a read");

  sequence q_cmd_a_err;
    avs_write_in && s.waitrequest && avs_address_in == `IDX_CMD_A &&
      avs_writedata_in[7:4] == `CMD_RST_ERR && !rx_valid_in[0];
  endsequence
  property p_err_clr;
    q_cmd_a_err |=> s.ch[0].acc == 3'h0 &&
      s.ch[0].rq[s.ch[0].rrd][10:8] == 3'h0;
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error bits survived the reset command");

  property p_block_keep;
    s.cfg[`CFG_BLOCK_BIT] &&
      !(avs_write_in && avs_address_in == `IDX_CMD_A) |=>
      (s.ch[0].acc & $past(s.ch[0].acc)) == $past(s.ch[0].acc);
  endproperty
  a_block_keep: assert property (p_block_keep)
    else $error("block errors dropped without a reset");

  property p_b_ready;
    rx_valid_in[1] && !s.ch[1].hv && s.ch[1].rcnt == 5'h00 &&
      !avs_write_in |=> s.ch[1].rxrdy;
  endproperty
  a_b_ready: assert property (p_b_ready)
    else $error("channel b rx ready not set");

  property p_low_pins;
    op_oe_out[2] |=> op_oe_out[1:0] == 2'h3 &&
      op_out[1:0] == $past(op_low_in);
  endproperty
  a_low_pins: assert property (p_low_pins)
    else $error("pins one and zero not from core logic");

  property p_mid_pins;
    op_oe_out[2] |-> op_oe_out[6:2] == 5'h1f &&
      op_out[6:2] == ~s.opv[6:2];
  endproperty
  a_mid_pins: assert property (p_mid_pins)
    else $error("pins six to two not inverse of port bits");

  property p_op7_release;
    op_oe_out[2] && s.opsel[`SEL_OP7_BIT] && !s.ch[1].txrdy |->
      !op_oe_out[7];
  endproperty
  a_op7_release: assert property (p_op7_release)
    else $error("pin seven driven while interrupt idle");

  property p_tx_room;
    s.ch[0].ten && s.ch[0].tcnt < `DEPTH_SHALLOW |-> s.ch[0].txrdy;
  endproperty
  a_tx_room: assert property (p_tx_room)
    else $error("tx ready low with free places");
endmodule : uart_status_outsel
`default_nettype wire

/* File: uart_so_shifter_model.sv */
// Stand-in for both transmit shift registers of the block.
// Assumes the block pops one character per take pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none
module uart_so_shifter_model (
  // Clock, reset and stall control.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  // Block side.
  input wire logic [1:0] valid_in,
  output logic [1:0] take_out,
  output logic [1:0] idle_out
);
  logic [1:0][2:0] busy;
  // The busy count keeps the shifter slow, so one word is never taken twice.
  always_ff @(posedge clk_in or posedge rst_in) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_in) begin
        take_out[i] <= 1'h0;
        busy[i] <= 3'h0;
      end else if (busy[i] != 3'h0) begin
        take_out[i] <= 1'h0;
        busy[i] <= busy[i] - 3'h1;
      end else begin
        take_out[i] <= valid_in[i] & ~stall_in;
        busy[i] <= {valid_in[i] & ~stall_in, 2'h0};
      end
    end
  end
  assign idle_out = {busy[1] == 3'h0, busy[0] == 3'h0};
endmodule : uart_so_shifter_model
`default_nettype wire

/* File: uart_status_and_output_select_tb.sv */
// Self-checking bench for the status flags and output pin selection.
// Assumes the shifter model drives both transmit handshakes.
`timescale 1ns/10ps
`default_nettype none
`include "uart_so_defs.svh"
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module uart_status_and_output_select_tb;
  logic sys_clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic stall = 1'h1;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq, irq;
  logic [1:0] rxv = 2'h0;
  logic [1:0] opl = 2'h0;
  logic [1:0][7:0] rxc = '0;
  logic [1:0][2:0] rxe = '0;
  logic [1:0] take, idle, txv;
  logic [1:0][7:0] txd;
  logic [7:0] op, oe, q, c, s;
  logic [31:0] seed = 32'h3b27;
  logic [7:0] txq[$];
  logic [7:0] sent[$];
  logic [10:0] rxq[$];
  logic [10:0] e;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  uart_status_outsel u_uart_status_outsel (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .rx_valid_in(rxv), .rx_char_in(rxc),
    .rx_err_in(rxe), .tx_take_in(take), .tx_idle_in(idle),
    .tx_valid_out(txv), .tx_data_out(txd), .op_low_in(opl),
    .op_out(op), .op_oe_out(oe), .irq_out(irq));
  uart_so_shifter_model u_uart_so_shifter_model (.clk_in(sys_clk_in),
    .rst_in(sys_rst_in), .stall_in(stall), .valid_in(txv),
    .take_out(take), .idle_out(idle));
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (take[0] === 1'h1) sent.push_back(txd[0]);
    if (cycles == 6000) begin
      err_count++;
      finish_test();
    end
  end
  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd8
  // Pins 7..2 as the select and port value should leave them.
  function automatic logic [5:0] pins(input logic [7:0] v, input logic s7);
    return {(s7 ? 1'h0 : ~v[7]), ~v[6:2]};
  endfunction : pins
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h0, d};
    @(posedge sys_clk_in);
    while (wreq !== 1'h0) begin
      @(posedge sys_clk_in);
    end
    q = rdat[7:0];
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge sys_clk_in);
  endtask : bus
  task automatic rs(input logic [3:0] a);
    bus(1'h0, a, 8'h00);
  endtask : rs
  task automatic push(input int ch, input logic [2:0] er);
    c = rnd8();
    rxc[ch] <= c;
    rxe[ch] <= er;
    rxv[ch] <= 1'h1;
    if (ch == 0) rxq.push_back({er, c});
    @(posedge sys_clk_in);
    rxv[ch] <= 1'h0;
    @(posedge sys_clk_in);
  endtask : push
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'h0;
    repeat (2) @(posedge sys_clk_in);
    `CMP(op[7:2], 6'h3f)
    `CMP(oe[7:2], 6'h3f)
    bus(1'h1, `IDX_CMD_A, 8'h04);
    rs(`IDX_STAT_A);
    `CMP(q[2], 1'h1)
    for (int i = 0; i < 8; i++) begin
      c = rnd8();
      txq.push_back(c);
      bus(1'h1, `IDX_DATA_A, c);
      rs(`IDX_STAT_A);
      `CMP(q[2], i < 7)
    end
    bus(1'h1, `IDX_DATA_A, 8'hee);
    stall <= 1'h0;
    repeat (100) @(posedge sys_clk_in);
    `CMP(sent.size(), 8)
    for (int i = 0; i < 8; i++) `CMP(sent[i], txq[i])
    rs(`IDX_STAT_A);
    `CMP(q[2], 1'h1)
    bus(1'h1, `IDX_CMD_A, 8'h08);
    rs(`IDX_STAT_A);
    `CMP(q[2], 1'h0)
    $display("transmit test ended");
    for (int i = 0; i < 9; i++) push(0, 3'(rnd8()));
    `CMP(irq, 1'h0)
    bus(1'h1, `IDX_MASK, 8'h01);
    repeat (2) @(posedge sys_clk_in);
    `CMP(irq, 1'h1)
    rs(`IDX_EVT);
    `CMP(q[0], 1'h1)
    repeat (2) @(posedge sys_clk_in);
    `CMP(irq, 1'h0)
    rs(`IDX_STAT_A);
    s = q;
    `CMP(q[1], 1'h1)
    rs(`IDX_STAT_A);
    `CMP(q, s)
    for (int i = 0; i < 9; i++) begin
      e = rxq.pop_front();
      rs(`IDX_STAT_A);
      `CMP(q[7:5], e[10:8])
      `CMP(q[1], i < 2)
      `CMP(q[0], 1'h1)
      rs(`IDX_DATA_A);
      `CMP(q, e[7:0])
    end
    rs(`IDX_STAT_A);
    `CMP(q[1:0], 2'h0)
    bus(1'h1, `IDX_CFG, 8'h02);
    push(0, 3'h2);
    push(0, 3'h0);
    rs(`IDX_DATA_A);
    rs(`IDX_STAT_A);
    `CMP(q[7:5], 3'h2)
    bus(1'h1, `IDX_CMD_A, 8'h40);
    rs(`IDX_STAT_A);
    `CMP(q[7:5], 3'h0)
    rs(`IDX_DATA_A);
    rxq.delete();
    bus(1'h1, `IDX_CFG, 8'h00);
    push(1, 3'h5);
    rs(`IDX_STAT_B);
    `CMP(q[7:5], 3'h5)
    `CMP(q[0], 1'h1)
    rs(`IDX_STAT_A);
    `CMP(q[0], 1'h0)
    rs(4'h7);
    `CMP(q, 8'h00)
    $display("receive test ended");
    c = rnd8();
    bus(1'h1, `IDX_OPV, c);
    opl <= 2'h2;
    repeat (2) @(posedge sys_clk_in);
    `CMP(op[7:2], pins(c, 1'h0))
    `CMP(op[1:0], 2'h2)
    bus(1'h1, `IDX_OPSEL, 8'h80);
    repeat (2) @(posedge sys_clk_in);
    `CMP(op[7:2], pins(c, 1'h1))
    `CMP(oe[7], 1'h0)
    bus(1'h1, `IDX_CMD_B, 8'h04);
    repeat (3) @(posedge sys_clk_in);
    `CMP(oe[7], 1'h1)
    `CMP(op[7], 1'h0)
    `CMP(oe[6:2], 5'h1f)
    $display("pin test ended");
    finish_test();
  end
endmodule : uart_status_and_output_select_tb
`default_nettype wire
